/* hw/fpu_pkg.sv */
// Constants, register map and types of the flash protection unit.
// Assumes one 100 MHz clock and an AXI4-Lite register port.
package fpu_pkg;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned ADDR_W       = 20;
  localparam int unsigned NUM_NV       = 5;
  localparam logic [19:0] OFF_WPL_MIR  = 20'hEDFB0;
  localparam logic [19:0] OFF_WPH_MIR  = 20'hEDFB2;
  localparam logic [19:0] OFF_WPL      = 20'hEDFB4;
  localparam logic [19:0] OFF_WPH      = 20'hEDFB6;
  localparam logic [19:0] OFF_APR0     = 20'hEDFB8;
  localparam logic [19:0] OFF_APR1L    = 20'hEDFBC;
  localparam logic [19:0] OFF_APR1H    = 20'hEDFBE;
  localparam logic [19:0] OFF_CTRL     = 20'hEDFC0;
  localparam logic [19:0] OFF_PROG     = 20'hEDFC4;
  localparam logic [19:0] OFF_UNPROT   = 20'hEDFC8;
  localparam logic [15:0] RST_WP       = 16'hFFFF;
  localparam logic [15:0] RST_APR0     = 16'hACFF;
  localparam logic [15:0] FORCE_ACT    = 16'h0000;
  localparam int unsigned BIT_BUSY     = 1;
  localparam int unsigned BIT_DBG      = 1;
  localparam int unsigned BIT_ACC      = 0;
  localparam int unsigned B0_LOW_N     = 10;
  localparam int unsigned HI_N         = 2;
  localparam int unsigned SECT_N       = 12;
  localparam int unsigned B1_SECT_N    = 2;
  localparam logic [2:0]  IDX_WPL      = 3'h0;
  localparam logic [2:0]  IDX_WPH      = 3'h1;
  localparam logic [2:0]  IDX_APR0     = 3'h2;
  localparam logic [2:0]  IDX_APR1L    = 3'h3;
  localparam logic [2:0]  IDX_APR1H    = 3'h4;
  localparam logic [2:0]  IDX_NONE     = 3'h7;
  localparam int unsigned PROG_TIME_NS = 1000;
  localparam int unsigned PROG_CYC     = (PROG_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam logic [15:0] DUMMY_DATA   = 16'h0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_IDLE = 2'b01,
    ST_PROG = 2'b10
  } fpu_state_t;
endpackage : fpu_pkg

/* hw/fpu_nv_cells.sv */
// One-time-programmable protection cells: bits only go from one to zero.
// Assumes program pulses come from the protection unit only.
// Cells have no reset: they start erased and keep their contents across resets.
`timescale 1ns/1ps
module fpu_nv_cells
  import fpu_pkg::*;
#(
  parameter int unsigned NUM = NUM_NV
) (
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              prog_en,
  input  wire logic [2:0]        prog_idx,
  input  wire logic [15:0]       prog_data,
  output logic      [NUM*16-1:0] cells
);
  // Erased contents of a fresh part
  function automatic logic [NUM*16-1:0] delivery();
    logic [NUM*16-1:0] v;
    for (int i = 0; i < NUM; i++) begin
      v[i*16 +: 16] = (i == int'(IDX_APR0)) ? RST_APR0 : RST_WP;
    end
    return v;
  endfunction : delivery

  localparam logic [NUM*16-1:0] DELIVERY = delivery();

  logic [NUM*16-1:0] cells_q = DELIVERY;
  logic [NUM*16-1:0] next_cells;

  assign cells = cells_q;

  // Programming only clears bits; a one never returns; no programming in reset
  always_comb begin
    next_cells = cells_q;
    for (int i = 0; i < NUM; i++) begin
      if (prog_en && resetn && (prog_idx == 3'(i))) begin
        next_cells[i*16 +: 16] = cells_q[i*16 +: 16] & prog_data;
      end
    end
  end

  // No reset branch: a reset must bring back programmed protection, not erase it
  always_ff @(posedge clock) begin
    cells_q <= next_cells;
  end
endmodule : fpu_nv_cells

/* hw/fpu_top.sv */
// Flash protection unit: volatile protection copies, checks, AXI4-Lite slave.
// Assumes the CPU flags each data access and the origin of the current fetch.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module fpu_top
  import fpu_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC
) (
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              mem_req,
  input  wire logic              mem_write,
  input  wire logic              mem_is_fetch,
  input  wire logic              fetch_from_flash,
  input  wire logic [3:0]        mem_sector,
  input  wire logic              mem_bank,
  input  wire logic [15:0]       array_rdata,
  output logic                   array_req,
  output logic [15:0]            cpu_rdata,
  output logic                   access_trap,
  output logic                   write_blocked,
  output logic                   debug_enable,
  output logic                   test_mode_enable,
  output logic                   load_done
);
  fpu_state_t        state;
  fpu_state_t        next_state;
  logic [NUM_NV*16-1:0] cells;
  logic [15:0]       vol [NUM_NV];
  logic [15:0]       next_vol [NUM_NV];
  logic [31:0]       cnt;
  logic [31:0]       next_cnt;
  logic [2:0]        cmd_idx;
  logic [2:0]        next_cmd_idx;
  logic [15:0]       cmd_data;
  logic [15:0]       next_cmd_data;
  logic              nv_prog;
  logic              loaded;
  logic              next_loaded;
  logic              aw_held;
  logic              next_aw_held;
  logic              w_held;
  logic              next_w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0]       w_data;
  logic [31:0]       next_w_data;
  logic [3:0]        w_strb;
  logic [3:0]        next_w_strb;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              wr_fire;
  logic [15:0]       wr_val;
  logic [15:0]       next_cpu_rdata;
  logic [15:0]       wpl_view;
  logic [15:0]       eff_wpl;
  logic [15:0]       eff_wph;
  logic [15:0]       eff_apr0;
  logic [SECT_N-1:0] b0_lock;
  logic [B1_SECT_N-1:0] b1_lock;
  logic              acc_block;
  logic              wr_lock;
  logic              sect_lock;
  logic              nv_busy_flag;

  // Non-volatile fuse store: two write and three access registers
  fpu_nv_cells #(.NUM(NUM_NV)) u_cells (
    .clock     (clock),
    .resetn    (resetn),
    .prog_en   (nv_prog),
    .prog_idx  (cmd_idx),
    .prog_data (cmd_data),
    .cells     (cells)
  );

  // Effective settings: forced active until the copy is loaded
  assign eff_wpl  = loaded ? vol[IDX_WPL]  : FORCE_ACT;
  assign eff_wph  = loaded ? vol[IDX_WPH]  : FORCE_ACT;
  assign eff_apr0 = loaded ? vol[IDX_APR0] : FORCE_ACT;
  assign nv_busy_flag = (state == ST_PROG);

  // Per-sector locks; one high bit covers a bank0 and a bank1 sector
  genvar g;
  generate
    for (g = 0; g < SECT_N; g++) begin : g_b0
      if (g < B0_LOW_N) begin : g_lo
        assign b0_lock[g] = ~eff_wpl[g];
      end else begin : g_hi
        assign b0_lock[g] = ~eff_wph[g-B0_LOW_N];
      end
    end
    for (g = 0; g < B1_SECT_N; g++) begin : g_b1
      assign b1_lock[g] = ~eff_wph[g];
    end
  endgenerate

  // Request-cycle checks gate the array directly
  always_comb begin
    sect_lock = 1'b0;
    if (mem_bank) begin
      if (mem_sector < 4'(B1_SECT_N)) sect_lock = b1_lock[mem_sector[0]];
    end else if (mem_sector < 4'(SECT_N)) begin
      sect_lock = b0_lock[mem_sector];
    end
    acc_block = mem_req && !mem_is_fetch && !fetch_from_flash && !eff_apr0[BIT_ACC];
    wr_lock = mem_req && mem_write && sect_lock;
  end
  assign array_req     = mem_req && !acc_block && !wr_lock;
  assign access_trap   = acc_block && !mem_write;
  assign write_blocked = (acc_block && mem_write) || wr_lock;
  assign next_cpu_rdata = access_trap ? DUMMY_DATA : array_rdata;

  // Debug paths follow the debug lock, closed until loaded
  assign debug_enable     = eff_apr0[BIT_DBG];
  assign test_mode_enable = eff_apr0[BIT_DBG];
  assign load_done        = loaded;

  // Low register view mirrors high bits 1:0 into bits 11:10
  always_comb begin
    wpl_view = vol[IDX_WPL];
    wpl_view[SECT_N-1:B0_LOW_N] = vol[IDX_WPH][HI_N-1:0];
  end

  // Address decode shared by both register aliases
  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [2:0] r;
    r = IDX_NONE;
    if (a == OFF_WPL || a == OFF_WPL_MIR) r = IDX_WPL;
    if (a == OFF_WPH || a == OFF_WPH_MIR) r = IDX_WPH;
    if (a == OFF_APR0)  r = IDX_APR0;
    if (a == OFF_APR1L) r = IDX_APR1L;
    if (a == OFF_APR1H) r = IDX_APR1H;
    return r;
  endfunction : reg_index

  // AXI4-Lite write channel: capture address and data in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_val  = w_data[15:0];
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      if (aw_addr == OFF_PROG || aw_addr == OFF_UNPROT) begin
        if (state != ST_IDLE || w_data[18:16] > IDX_APR1H) next_bresp = RESP_SLVERR;
      end else if (aw_addr != OFF_CTRL && reg_index(aw_addr) == IDX_NONE) begin
        next_bresp = RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Protection command engine and volatile copies
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_cmd_idx  = cmd_idx;
    next_cmd_data = cmd_data;
    next_loaded   = loaded;
    nv_prog       = 1'b0;
    for (int i = 0; i < NUM_NV; i++) next_vol[i] = vol[i];
    unique case (state)
      ST_LOAD: begin
        for (int i = 0; i < NUM_NV; i++) next_vol[i] = cells[i*16 +: 16];
        next_loaded = 1'b1;
        next_state  = ST_IDLE;
      end
      ST_IDLE: begin
        if (wr_fire && w_strb[1:0] == 2'b11 && w_data[18:16] <= IDX_APR1H) begin
          if (aw_addr == OFF_PROG) begin
            next_cmd_idx  = w_data[18:16];
            next_cmd_data = wr_val;
            next_cnt      = 32'(PROG_CYCLES);
            next_state    = ST_PROG;
          end else if (aw_addr == OFF_UNPROT) begin
            next_vol[w_data[18:16]] = vol[w_data[18:16]] | wr_val;
          end
        end
      end
      ST_PROG: begin
        if (cnt > 32'd1) begin
          next_cnt = cnt - 32'd1;
        end else begin
          nv_prog    = 1'b1;
          // Zero bits restore protection in the copy as well
          next_vol[cmd_idx] = vol[cmd_idx] & cmd_data;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_LOAD;
    endcase
  end

  // AXI4-Lite read channel, one outstanding read
  assign s_axi_arready = !s_axi_rvalid;
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      if (s_axi_araddr == OFF_CTRL) begin
        next_rdata[BIT_BUSY] = nv_busy_flag;
      end else begin
        unique case (reg_index(s_axi_araddr))
          IDX_WPL:   next_rdata[15:0] = wpl_view;
          IDX_WPH:   next_rdata[15:0] = vol[IDX_WPH];
          IDX_APR0:  next_rdata[15:0] = vol[IDX_APR0];
          IDX_APR1L: next_rdata[15:0] = vol[IDX_APR1L];
          IDX_APR1H: next_rdata[15:0] = vol[IDX_APR1H];
          default:   next_rresp = RESP_SLVERR;
        endcase
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state        <= ST_LOAD;
      cnt          <= 32'h0000_0000;
      cmd_idx      <= 3'h0;
      cmd_data     <= RST_WP;
      loaded       <= 1'b0;
      for (int i = 0; i < NUM_NV; i++) vol[i] <= FORCE_ACT;
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
      cpu_rdata    <= DUMMY_DATA;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      cmd_idx      <= next_cmd_idx;
      cmd_data     <= next_cmd_data;
      loaded       <= next_loaded;
      for (int i = 0; i < NUM_NV; i++) vol[i] <= next_vol[i];
      aw_held      <= next_aw_held;
      w_held       <= next_w_held;
      aw_addr      <= next_aw_addr;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
      cpu_rdata    <= next_cpu_rdata;
    end
  end
endmodule : fpu_top

/* tb/fpu_checker.sv */
// Port-level checker of the flash protection unit.
// Bound to fpu_top from the bench top; one clock domain, reset active low.
`timescale 1ns/1ps
module fpu_checker
  import fpu_pkg::*;
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        mem_req,
  input wire logic        mem_write,
  input wire logic        mem_is_fetch,
  input wire logic        fetch_from_flash,
  input wire logic [15:0] array_rdata,
  input wire logic        array_req,
  input wire logic [15:0] cpu_rdata,
  input wire logic        access_trap,
  input wire logic        write_blocked,
  input wire logic        debug_enable,
  input wire logic        test_mode_enable,
  input wire logic        load_done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Blocking decisions and what they let through
  property p_trap_cause;
    access_trap |-> mem_req && !mem_write && !mem_is_fetch && !fetch_from_flash;
  endproperty
  a_trap_cause: assert property (p_trap_cause) else $error("trap without cause");
  property p_trap_noreq; access_trap |-> !array_req; endproperty
  a_trap_noreq: assert property (p_trap_noreq) else $error("trapped read hit array");
  property p_wb_cause; write_blocked |-> mem_req && mem_write; endproperty
  a_wb_cause: assert property (p_wb_cause) else $error("blocked flag without write");
  property p_wb_noreq; write_blocked |-> !array_req; endproperty
  a_wb_noreq: assert property (p_wb_noreq) else $error("blocked write hit array");
  property p_fetch; mem_req && mem_is_fetch |-> array_req; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch refused");
  property p_flash_read;
    mem_req && !mem_write && fetch_from_flash && load_done |-> array_req && !access_trap;
  endproperty
  a_flash_read: assert property (p_flash_read) else $error("inside read refused");
  property p_dummy; access_trap |=> cpu_rdata == 16'h0000; endproperty
  a_dummy: assert property (p_dummy) else $error("trapped read not dummy");
  property p_rdata; mem_req && !mem_write && array_req |=> cpu_rdata == $past(array_rdata);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data lost");
  property p_unloaded; !load_done |-> !debug_enable && !test_mode_enable; endproperty
  a_unloaded: assert property (p_unloaded) else $error("debug open before load");
  property p_load; $rose(resetn) |-> ##[0:2] load_done; endproperty
  a_load: assert property (p_load) else $error("load not done in time");
  // Main scenarios seen
  c_trap: cover property (access_trap);
  c_wb: cover property (write_blocked);
  c_fetch: cover property (mem_req && mem_is_fetch && array_req);
endmodule : fpu_checker

/* tb/fpu_array_model.sv */
// Program memory array model on the far side of the protection unit.
// Answers in the request cycle; an idle bus shows the inverse of the last word.
`timescale 1ns/1ps
module fpu_array_model (
  input  wire logic        clock,
  input  wire logic        array_req,
  input  wire logic        mem_write,
  input  wire logic [3:0]  mem_sector,
  input  wire logic        mem_bank,
  output logic      [15:0] array_rdata,
  output int               n_writes
);
  logic [15:0] last_data = 16'h0000;
  int          count     = 0;
  assign n_writes = count;
  // Word content follows the target location
  always_comb begin
    if (array_req) begin
      array_rdata = {8'hA5, 3'h0, mem_bank, mem_sector};
    end else begin
      array_rdata = ~last_data;
    end
  end
  // Remember the bus and count writes that really arrive
  always @(posedge clock) begin
    last_data <= array_rdata;
    if (array_req && mem_write) count <= count + 1;
  end
endmodule : fpu_array_model

/* tb/flash_protection_unit_tb.sv */
// Self-checking bench of the flash protection unit.
// Drives AXI4-Lite and the CPU port; the array model answers reads.
`timescale 1ns/1ps
module flash_protection_unit_tb;
  import fpu_pkg::*;
  logic        clock = 0, resetn = 0;
  logic [19:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, array_req, access_trap;
  logic        mem_req = 0, mem_write = 0, mem_is_fetch = 0, mem_bank = 0;
  logic        fetch_from_flash = 0;
  logic        write_blocked, debug_enable, test_mode_enable, load_done;
  logic [3:0]  mem_sector = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [15:0] array_rdata, cpu_rdata, wl = 16'hFFFF, wh = 16'hFFFF;
  int          n_fail = 0, tests_run = 0, cyc = 0, n_writes, wc, s, i;
  integer      seed = 32'h2355;
  logic [19:0] adr [7] = '{OFF_WPL_MIR, OFF_WPH_MIR, OFF_WPL, OFF_WPH, OFF_APR0, OFF_APR1L,
                           OFF_APR1H};
  logic [15:0] rst [7] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hACFF, 16'hFFFF,
                           16'hFFFF};

  fpu_top #(.PROG_CYCLES(40)) dut (.clock, .resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_write,
    .mem_is_fetch, .fetch_from_flash, .mem_sector, .mem_bank, .array_rdata, .array_req,
    .cpu_rdata, .access_trap, .write_blocked, .debug_enable, .test_mode_enable, .load_done);
  fpu_array_model u_mem (.clock, .array_req, .mem_write, .mem_sector, .mem_bank,
    .array_rdata, .n_writes);

  // Clock and hang guard
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  function automatic logic [15:0] pat(input logic b, input logic [3:0] sc);
    return {8'hA5, 3'h0, b, sc};
  endfunction : pat
  function automatic logic [15:0] lowv(input logic [15:0] l, input logic [15:0] h);
    return {l[15:12], h[1:0], l[9:0]};
  endfunction : lowv

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [19:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ga, gw, gb;
    ga = 0;
    gw = 0;
    gb = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ga && gw)) begin
      @(negedge clock);
      ga = ga | (s_axi_awvalid & s_axi_awready);
      gw = gw | (s_axi_wvalid & s_axi_wready);
      @(posedge clock);
      if (ga) s_axi_awvalid <= 1'b0;
      if (gw) s_axi_wvalid <= 1'b0;
    end
    while (!gb) begin
      @(negedge clock);
      gb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clock);
    end
    s_axi_bready <= 1'b0;
    chk(r, er);
  endtask : wr
  task automatic rd(input logic [19:0] a);
    logic g;
    g = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!g) begin
      @(negedge clock);
      g = s_axi_arready;
      @(posedge clock);
    end
    s_axi_arvalid <= 1'b0;
    g = 0;
    while (!g) begin
      @(negedge clock);
      g = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
    end
    s_axi_rready <= 1'b0;
  endtask : rd
  // Command, busy while running, second command refused, wait for idle
  task automatic prog(input logic [2:0] idx, input logic [15:0] v);
    int k;
    wr(OFF_PROG, {13'h0, idx, v}, RESP_OKAY);
    rd(OFF_CTRL);
    chk(d[BIT_BUSY], 1'b1);
    wr(OFF_PROG, {13'h0, idx, v}, RESP_SLVERR);
    k = 0;
    while (d[BIT_BUSY] === 1'b1 && k < 40) begin
      rd(OFF_CTRL);
      k++;
    end
    chk(d[BIT_BUSY], 1'b0);
  endtask : prog
  // One CPU access; e is {array_req, access_trap, write_blocked}
  task automatic cpu(input logic w, f, ff, b, input logic [3:0] sc, input logic [2:0] e);
    @(posedge clock);
    mem_req <= 1'b1;
    mem_write <= w;
    mem_is_fetch <= f;
    fetch_from_flash <= ff;
    mem_bank <= b;
    mem_sector <= sc;
    @(negedge clock);
    chk({array_req, access_trap, write_blocked}, e);
    @(posedge clock);
    mem_req <= 1'b0;
    fetch_from_flash <= 1'b0;
    @(negedge clock);
    if (!w) chk(cpu_rdata, e[1] ? 16'h0000 : pat(b, sc));
  endtask : cpu
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    chk(debug_enable, 1'b0);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk(load_done, 1'b1);
    chk({debug_enable, test_mode_enable}, 2'b11);
    for (i = 0; i < 7; i++) begin
      rd(adr[i]);
      chk(d, {16'h0, rst[i]});
    end
    rd(20'h00010);
    chk({d, r}, {32'h0, RESP_SLVERR});
    wr(20'h00010, 32'h1234, RESP_SLVERR);
    wr(OFF_WPL, 32'h0, RESP_OKAY);
    rd(OFF_WPL);
    chk(d, 32'hFFFF);
    cpu(0, 0, 0, 0, 4'h3, 3'b100);
    $display("test reset values done");
    s = {$random(seed)} % 10;
    wl = 16'hFFFF & ~(16'h1 << s);
    prog(IDX_WPL, wl);
    rd(OFF_WPL_MIR);
    chk(d, {16'h0, lowv(wl, wh)});
    cpu(1, 0, 0, 0, s[3:0], 3'b001);
    cpu(1, 0, 0, 0, 4'((s + 1) % 10), 3'b100);
    wh = 16'hFFFE;
    prog(IDX_WPH, wh);
    rd(OFF_WPL);
    chk(d, {16'h0, lowv(wl, wh)});
    rd(OFF_WPH_MIR);
    chk(d, {16'h0, wh});
    cpu(1, 0, 0, 0, 4'hA, 3'b001);
    cpu(1, 0, 0, 1, 4'h0, 3'b001);
    cpu(1, 0, 0, 1, 4'h1, 3'b100);
    cpu(1, 0, 0, 0, 4'hB, 3'b100);
    $display("test write protection done");
    prog(IDX_APR0, 16'hACFE);
    rd(OFF_APR0);
    chk(d, 32'hACFE);
    cpu(0, 0, 0, 0, 4'h2, 3'b010);
    cpu(0, 1, 0, 0, 4'h2, 3'b100);
    wc = n_writes;
    cpu(1, 0, 0, 1, 4'h1, 3'b001);
    chk(n_writes, wc);
    for (i = 0; i < 6; i++) begin
      s = $random(seed);
      cpu(0, 0, 1, s[4], s[4] ? 4'(s[0]) : 4'({s[3:0]} % 12), 3'b100);
    end
    wr(OFF_UNPROT, {13'h0, IDX_APR0, 16'h0001}, RESP_OKAY);
    cpu(0, 0, 0, 0, 4'h2, 3'b100);
    prog(IDX_APR0, 16'hACFE);
    cpu(0, 0, 0, 0, 4'h2, 3'b010);
    prog(IDX_APR0, 16'hACFD);
    chk({debug_enable, test_mode_enable}, 2'b00);
    $display("test access protection done");
    // Mid-run reset: programmed cells must come back into the copies
    @(posedge clock);
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    chk({debug_enable, load_done}, 2'b00);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk({load_done, debug_enable, test_mode_enable}, 3'b100);
    rd(OFF_APR0);
    chk(d, 32'hACFC);
    rd(OFF_WPL);
    chk(d, {16'h0, lowv(wl, wh)});
    cpu(0, 0, 0, 0, 4'h2, 3'b010);
    cpu(1, 0, 0, 0, 4'hA, 3'b001);
    $display("test reset persistence done");
    report_and_stop();
  end
endmodule : flash_protection_unit_tb

bind fpu_top fpu_checker u_chk (.clock, .resetn, .mem_req, .mem_write, .mem_is_fetch,
  .fetch_from_flash, .array_rdata, .array_req, .cpu_rdata, .access_trap, .write_blocked,
  .debug_enable, .test_mode_enable, .load_done);
